// *** jmm_cnt.v ***
// Loadable down counter with a zero flag.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module jmm_cnt #(
	parameter W = 16
) (
	input wire clk_sys,
	input wire reset_n,
	input wire load,
	input wire [W-1:0] load_val,
	input wire dec,
	output wire zero
);
	reg [W-1:0] cnt_r;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= {W{1'b0}};
		end else if (load) begin
			cnt_r <= load_val;
		end else if (dec && (cnt_r != {W{1'b0}})) begin
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign zero = (cnt_r == {W{1'b0}});
endmodule

// *** jmm_jog.v ***
// Jog operating mode sequencer: parameter store, request decoding and
// step / pause / continuous motion sequencing.
// Assumes a motion profile generator downstream that follows run, direction
// and speed, and reports standstill and one pulse per user unit travelled.
// Behaviour
// - Continuous jog runs while request held
// - Brief step request moves step distance once
// - Held step: step, pause, then continuous
// - Input zero enables power, one clears fault
// - Input two negative, input three positive
// - Mode code activates jog, command starts motion
// - Command bits: positive, negative, fast select
// - Both directions while idle start nothing
// - Both directions while running are ignored
// - Command accepts 0 to 7, immediate
// - Status bits 10 and 12 reserved
// - Ends at standstill with stop cause
// - Fast/slow input picks speed on inputs
// - Slow speed 1..13200, default 60, clamped
// - Fast speed 1..13200, default 180, clamped
// - Step distance 0..max, default 20, next move
// - Pause 1..32767 ms, default 500, next move
// - Mode -1 selects jog, starts with power
`timescale 1ns/1ps
`include "jmm_regs.vh"
module jmm_jog #(
	parameter MS_CYCLES = `JMM_MS_PS / `JMM_CLK_PERIOD_PS
) (
	input wire clk_sys,
	input wire reset_n,
	input wire par_wr,
	input wire par_rd,
	input wire [15:0] par_addr,
	input wire [31:0] par_wdata,
	output reg [31:0] par_rdata,
	output reg par_ack,
	output reg par_err,
	input wire cfg_di_enable,
	input wire cfg_di_fault_reset,
	input wire cfg_di_jog,
	input wire cfg_di_fast_slow,
	input wire enable_input,
	input wire fault_clear_input,
	input wire negative_direction_input,
	input wire positive_direction_input,
	input wire fast_slow_input,
	input wire jog_method_step,
	input wire halt_req,
	input wire quick_stop_req,
	input wire fault_active,
	input wire motor_standstill,
	input wire unit_moved,
	input wire [15:0] ramp_speed_limit,
	output reg power_stage_en,
	output reg fault_reset_pulse,
	output wire jog_mode_active,
	output reg motion_run,
	output reg motion_dir_neg,
	output reg [15:0] speed_ref,
	output reg [1:0] status_mode_bits,
	output reg [2:0] jog_state
);
	// ************************************************************
	// States
	// ************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_STEP = 3'h1;
	localparam ST_PAUSE = 3'h2;
	localparam ST_CONT = 3'h3;
	localparam ST_STOP = 3'h4;

	localparam integer PRESC_INT = MS_CYCLES - 1;
	localparam [`JMM_PRESC_W-1:0] PRESC_LOAD = PRESC_INT[`JMM_PRESC_W-1:0];

	// ************************************************************
	// Parameter store
	// ************************************************************
	reg [15:0] mode_select_r;
	reg [15:0] jog_cmd_r;
	reg [15:0] slow_speed_r;
	reg [15:0] fast_speed_r;
	reg [31:0] step_dist_r;
	reg [15:0] step_pause_r;
	reg wr_ok;
	reg hit;

	always @* begin
		hit = 1'b1;
		wr_ok = 1'b0;
		case (par_addr)
		`JMM_ADDR_MODE_SELECT: begin
			wr_ok = ($signed(par_wdata[15:0]) >= $signed(`JMM_MODE_MIN)) &&
				($signed(par_wdata[15:0]) <= $signed(`JMM_MODE_MAX));
		end
		`JMM_ADDR_JOG_CMD: begin
			wr_ok = (par_wdata[15:0] <= `JMM_CMD_MAX);
		end
		`JMM_ADDR_SLOW_SPEED, `JMM_ADDR_FAST_SPEED: begin
			wr_ok = (par_wdata[15:0] >= `JMM_SPEED_MIN) &&
				(par_wdata[15:0] <= `JMM_SPEED_MAX);
		end
		`JMM_ADDR_STEP_DIST: begin
			wr_ok = (par_wdata <= `JMM_DIST_MAX);
		end
		`JMM_ADDR_STEP_PAUSE: begin
			wr_ok = (par_wdata[15:0] >= `JMM_PAUSE_MIN) &&
				(par_wdata[15:0] <= `JMM_PAUSE_MAX);
		end
		default: begin
			hit = 1'b0;
		end
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_select_r <= `JMM_RST_MODE_SELECT;
			jog_cmd_r <= `JMM_RST_JOG_CMD;
			slow_speed_r <= `JMM_RST_SLOW_SPEED;
			fast_speed_r <= `JMM_RST_FAST_SPEED;
			step_dist_r <= `JMM_RST_STEP_DIST;
			step_pause_r <= `JMM_RST_STEP_PAUSE;
			par_rdata <= 32'h00000000;
			par_ack <= 1'b0;
			par_err <= 1'b0;
		end else begin
			par_ack <= par_wr | par_rd;
			par_err <= (par_wr | par_rd) & ~hit | par_wr & hit & ~wr_ok;
			if (par_wr && wr_ok) begin
				case (par_addr)
				`JMM_ADDR_MODE_SELECT: mode_select_r <= par_wdata[15:0];
				`JMM_ADDR_JOG_CMD: jog_cmd_r <= par_wdata[15:0];
				`JMM_ADDR_SLOW_SPEED: slow_speed_r <= par_wdata[15:0];
				`JMM_ADDR_FAST_SPEED: fast_speed_r <= par_wdata[15:0];
				`JMM_ADDR_STEP_DIST: step_dist_r <= par_wdata;
				`JMM_ADDR_STEP_PAUSE: step_pause_r <= par_wdata[15:0];
				default: mode_select_r <= mode_select_r;
				endcase
			end
			if (par_rd) begin
				case (par_addr)
				`JMM_ADDR_MODE_SELECT: par_rdata <= {16'h0000, mode_select_r};
				`JMM_ADDR_JOG_CMD: par_rdata <= {16'h0000, jog_cmd_r};
				`JMM_ADDR_SLOW_SPEED: par_rdata <= {16'h0000, slow_speed_r};
				`JMM_ADDR_FAST_SPEED: par_rdata <= {16'h0000, fast_speed_r};
				`JMM_ADDR_STEP_DIST: par_rdata <= step_dist_r;
				`JMM_ADDR_STEP_PAUSE: par_rdata <= {16'h0000, step_pause_r};
				default: par_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ************************************************************
	// Discrete inputs: power stage and fault reset
	// ************************************************************
	reg enable_d_r;
	reg fault_clear_d_r;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			enable_d_r <= 1'b0;
			fault_clear_d_r <= 1'b0;
			power_stage_en <= 1'b0;
			fault_reset_pulse <= 1'b0;
		end else begin
			enable_d_r <= enable_input;
			fault_clear_d_r <= fault_clear_input;
			fault_reset_pulse <= cfg_di_fault_reset & fault_clear_input &
				~fault_clear_d_r;
			if (cfg_di_enable && enable_input && !enable_d_r) begin
				power_stage_en <= 1'b1;
			end else if (cfg_di_enable && !enable_input && enable_d_r) begin
				power_stage_en <= 1'b0;
			end else if (fault_active) begin
				power_stage_en <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Request decoding
	// ************************************************************
	wire req_pos;
	wire req_neg;
	wire req_fast;
	wire stop_cause;
	wire jog_active_c;
	reg jog_active_r;

	assign jog_active_c = power_stage_en & (mode_select_r == `JMM_MODE_JOG);
	assign jog_mode_active = jog_active_r;
	assign req_pos = cfg_di_jog ? positive_direction_input :
		jog_cmd_r[`JMM_CMD_POS_BIT];
	assign req_neg = cfg_di_jog ? negative_direction_input :
		jog_cmd_r[`JMM_CMD_NEG_BIT];
	assign req_fast = (cfg_di_jog && cfg_di_fast_slow) ? fast_slow_input :
		jog_cmd_r[`JMM_CMD_FAST_BIT];
	assign stop_cause = halt_req | quick_stop_req | fault_active | ~jog_active_c;

	// ************************************************************
	// Step distance and pause timers
	// ************************************************************
	reg [15:0] pause_lat_r;
	wire dist_zero;
	wire presc_zero;
	wire pause_zero;
	wire step_load;
	wire pause_load;
	wire req_dir;
	wire [15:0] pause_lat_m1;

	assign req_dir = motion_dir_neg ? req_neg : req_pos;
	// Last ms tick of the prescaler ends the pause exactly
	assign pause_lat_m1 = pause_lat_r - 16'h0001;
	assign step_load = (jog_state == ST_IDLE);
	assign pause_load = (jog_state == ST_STEP);

	jmm_cnt #(.W(32)) u_dist (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load(step_load),
		.load_val(step_dist_r),
		.dec((jog_state == ST_STEP) & unit_moved),
		.zero(dist_zero)
	);

	jmm_cnt #(.W(`JMM_PRESC_W)) u_presc (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load(pause_load | presc_zero),
		.load_val(PRESC_LOAD),
		.dec(jog_state == ST_PAUSE),
		.zero(presc_zero)
	);

	jmm_cnt #(.W(16)) u_pause (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load(pause_load),
		.load_val(pause_lat_m1),
		.dec((jog_state == ST_PAUSE) & presc_zero),
		.zero(pause_zero)
	);

	// ************************************************************
	// Motion sequencer
	// ************************************************************
	reg [2:0] state_nxt;

	always @* begin
		state_nxt = jog_state;
		case (jog_state)
		ST_IDLE: begin
			if (!stop_cause && (req_pos ^ req_neg)) begin
				state_nxt = jog_method_step ? ST_STEP : ST_CONT;
			end
		end
		ST_STEP: begin
			if (stop_cause) begin
				state_nxt = ST_STOP;
			end else if (dist_zero) begin
				state_nxt = req_dir ? ST_PAUSE : ST_STOP;
			end
		end
		ST_PAUSE: begin
			if (stop_cause || !req_dir) begin
				state_nxt = ST_STOP;
			end else if (pause_zero && presc_zero) begin
				state_nxt = ST_CONT;
			end
		end
		ST_CONT: begin
			if (stop_cause || !req_dir) begin
				state_nxt = ST_STOP;
			end
		end
		ST_STOP: begin
			if (motor_standstill) begin
				state_nxt = ST_IDLE;
			end
		end
		default: begin
			state_nxt = ST_STOP;
		end
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			jog_state <= ST_IDLE;
			motion_dir_neg <= 1'b0;
			pause_lat_r <= `JMM_RST_STEP_PAUSE;
			motion_run <= 1'b0;
			speed_ref <= 16'h0000;
			status_mode_bits <= 2'b00;
			jog_active_r <= 1'b0;
		end else begin
			jog_state <= state_nxt;
			jog_active_r <= jog_active_c;
			status_mode_bits <= 2'b00;
			if (jog_state == ST_IDLE) begin
				motion_dir_neg <= req_neg;
				pause_lat_r <= step_pause_r;
			end
			motion_run <= (state_nxt == ST_STEP) || (state_nxt == ST_CONT);
			if (req_fast) begin
				speed_ref <= (fast_speed_r > ramp_speed_limit) ?
					ramp_speed_limit : fast_speed_r;
			end else begin
				speed_ref <= (slow_speed_r > ramp_speed_limit) ?
					ramp_speed_limit : slow_speed_r;
			end
		end
	end
endmodule

// *** jmm_jog_asserts.sv ***
// Port-level checks of the jog sequencer.
// Assumes binding to jmm_jog, one clock, reset_n asynchronous active low.
`timescale 1ns/1ps
module jmm_jog_asserts (
	input wire clk_sys,
	input wire reset_n,
	input wire par_wr,
	input wire par_rd,
	input wire par_ack,
	input wire cfg_di_jog,
	input wire cfg_di_fault_reset,
	input wire fault_clear_input,
	input wire negative_direction_input,
	input wire positive_direction_input,
	input wire motor_standstill,
	input wire [15:0] ramp_speed_limit,
	input wire fault_reset_pulse,
	input wire jog_mode_active,
	input wire motion_run,
	input wire [15:0] speed_ref,
	input wire [1:0] status_mode_bits,
	input wire [2:0] jog_state
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!reset_n);
chk_ack_after_req: assert property ((par_wr || par_rd) |=> par_ack)
	else $error("ack missing");
chk_ack_no_req: assert property (!(par_wr || par_rd) |=> !par_ack)
	else $error("ack without request");
chk_status_reserved: assert property (status_mode_bits == 2'b00)
	else $error("reserved status bits set");
chk_both_idle: assert property ((jog_state == 3'h0 && cfg_di_jog && negative_direction_input
	&& positive_direction_input) |=> !motion_run)
	else $error("start on both inputs");
chk_run_needs_mode: assert property ($rose(motion_run) |-> jog_mode_active)
	else $error("run without jog mode");
chk_speed_clamp: assert property (speed_ref <= $past(ramp_speed_limit))
	else $error("speed above limit");
chk_stop_standstill: assert property ((jog_state == 3'h4 && !motor_standstill)
	|=> jog_state != 3'h0)
	else $error("idle before standstill");
chk_fault_reset: assert property ((cfg_di_fault_reset && $rose(fault_clear_input))
	|=> fault_reset_pulse)
	else $error("fault reset missing");
chk_pause_stopped: assert property (jog_state == 3'h2 |-> !motion_run)
	else $error("run during pause");
endmodule
bind jmm_jog jmm_jog_asserts u_chk (.clk_sys, .reset_n, .par_wr, .par_rd, .par_ack,
	.cfg_di_jog, .cfg_di_fault_reset, .fault_clear_input, .negative_direction_input,
	.positive_direction_input, .motor_standstill, .ramp_speed_limit, .fault_reset_pulse,
	.jog_mode_active, .motion_run, .speed_ref, .status_mode_bits, .jog_state);

// *** jmm_motor_model.sv ***
// Motion profile stand-in: one unit pulse every four run cycles.
// Assumes the sequencer's clock and reset; standstill four cycles after run drops.
`timescale 1ns/1ps
module jmm_motor_model (
	input wire clk_sys,
	input wire reset_n,
	input wire motion_run,
	output reg motor_standstill,
	output reg unit_moved
);
reg [1:0] div_r;
reg [1:0] idle_r;
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		div_r <= 2'h0;
		idle_r <= 2'h3;
		unit_moved <= 1'b0;
		motor_standstill <= 1'b1;
	end else begin
		div_r <= motion_run ? div_r + 2'h1 : 2'h0;
		unit_moved <= motion_run && div_r == 2'h3;
		idle_r <= motion_run ? 2'h0 : (idle_r == 2'h3 ? idle_r : idle_r + 2'h1);
		motor_standstill <= !motion_run && idle_r == 2'h3;
	end
end
endmodule

// *** jmm_regs.vh ***
// Constants of the jog mode sequencer: parameter addresses, reset values,
// field positions, limits and timing.
// Assumes inclusion by bare name from the design files.
`ifndef JMM_REGS_VH
`define JMM_REGS_VH

// ************************************************************
// Parameter addresses (fieldbus parameter port)
// ************************************************************
`define JMM_ADDR_MODE_SELECT 16'h1b06
`define JMM_ADDR_JOG_CMD 16'h1b12
`define JMM_ADDR_SLOW_SPEED 16'h2908
`define JMM_ADDR_FAST_SPEED 16'h290a
`define JMM_ADDR_STEP_DIST 16'h290e
`define JMM_ADDR_STEP_PAUSE 16'h2910

// ************************************************************
// Reset values
// ************************************************************
`define JMM_RST_MODE_SELECT 16'h0000
`define JMM_RST_JOG_CMD 16'h0000
`define JMM_RST_SLOW_SPEED 16'h003c
`define JMM_RST_FAST_SPEED 16'h00b4
`define JMM_RST_STEP_DIST 32'h00000014
`define JMM_RST_STEP_PAUSE 16'h01f4

// ************************************************************
// Fields and limits
// ************************************************************
`define JMM_CMD_POS_BIT 0
`define JMM_CMD_NEG_BIT 1
`define JMM_CMD_FAST_BIT 2
`define JMM_CMD_MAX 16'h0007
`define JMM_MODE_JOG 16'hffff
`define JMM_MODE_MIN 16'hfffc
`define JMM_MODE_MAX 16'h0006
`define JMM_SPEED_MIN 16'h0001
`define JMM_SPEED_MAX 16'h3390
`define JMM_DIST_MAX 32'h7fffffff
`define JMM_PAUSE_MIN 16'h0001
`define JMM_PAUSE_MAX 16'h7fff

// ************************************************************
// Timing
// ************************************************************
`define JMM_CLK_PERIOD_PS 5000
`define JMM_MS_PS 1000000000
`define JMM_PRESC_W 18

`endif

// *** jog_motion_mode_tb.sv ***
// Self-checking bench of the jog sequencer over parameter port and inputs.
// Assumes jmm_jog, its checker and jmm_motor_model compiled before.
`timescale 1ns/1ps
`include "jmm_regs.vh"
module jog_motion_mode_tb;
reg clk_sys = 1'b0;
reg reset_n = 1'b0;
reg par_wr = 1'b0, par_rd = 1'b0, cfg_di_enable = 1'b1, cfg_di_fault_reset = 1'b1;
reg cfg_di_jog = 1'b0, cfg_di_fast_slow = 1'b0, enable_input = 1'b0, fault_clear_input = 1'b0;
reg negative_direction_input = 1'b0, positive_direction_input = 1'b0, fast_slow_input = 1'b0;
reg jog_method_step = 1'b0, halt_req = 1'b0, quick_stop_req = 1'b0, fault_active = 1'b0;
reg [15:0] par_addr = 16'h0000;
reg [31:0] par_wdata = 32'h00000000;
reg [15:0] ramp_speed_limit = `JMM_SPEED_MAX;
wire [31:0] par_rdata;
wire [15:0] speed_ref;
wire [1:0] status_mode_bits;
wire [2:0] jog_state;
wire par_ack, par_err, motor_standstill, unit_moved, power_stage_en, fault_reset_pulse;
wire jog_mode_active, motion_run, motion_dir_neg;
integer n_fail = 0;
integer check_count = 0;
integer n_wait;
localparam MS_TB = 10;
jmm_jog #(.MS_CYCLES(MS_TB)) dut (.clk_sys, .reset_n, .par_wr, .par_rd, .par_addr, .par_wdata,
	.par_rdata, .par_ack, .par_err, .cfg_di_enable, .cfg_di_fault_reset, .cfg_di_jog,
	.cfg_di_fast_slow, .enable_input, .fault_clear_input, .negative_direction_input,
	.positive_direction_input, .fast_slow_input, .jog_method_step, .halt_req,
	.quick_stop_req, .fault_active, .motor_standstill, .unit_moved, .ramp_speed_limit,
	.power_stage_en, .fault_reset_pulse, .jog_mode_active, .motion_run, .motion_dir_neg,
	.speed_ref, .status_mode_bits, .jog_state);
jmm_motor_model u_motor (.clk_sys, .reset_n, .motion_run, .motor_standstill, .unit_moved);
initial forever #2.5 clk_sys = ~clk_sys;
task test_done;
	begin
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
endtask
task check(input [31:0] seen, input [31:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
endtask
// One-cycle parameter access; read data compared only on reads
task access(input wr, input [15:0] addr, input [31:0] data, input [31:0] exp, input err);
	begin
		par_wr = wr;
		par_rd = !wr;
		par_addr = addr;
		par_wdata = data;
		@(negedge clk_sys);
		check(par_ack, 1);
		check(par_err, err);
		if (!wr)
			check(par_rdata, exp);
		par_wr = 1'b0;
		par_rd = 1'b0;
		@(negedge clk_sys);
		check(par_ack, 0);
	end
endtask
task wait_state(input [2:0] s);
	integer n;
	begin
		n = 0;
		while (jog_state !== s && n < 200) begin
			@(negedge clk_sys);
			n = n + 1;
		end
		check(jog_state, s);
	end
endtask
initial begin
	repeat (20000) @(posedge clk_sys);
	n_fail = n_fail + 1;
	test_done;
end
initial begin
	repeat (16) @(negedge clk_sys);
	reset_n = 1'b1;
	@(negedge clk_sys);
	access(0, `JMM_ADDR_JOG_CMD, 0, `JMM_RST_JOG_CMD, 0);
	access(0, `JMM_ADDR_SLOW_SPEED, 0, `JMM_RST_SLOW_SPEED, 0);
	access(0, `JMM_ADDR_FAST_SPEED, 0, `JMM_RST_FAST_SPEED, 0);
	access(0, `JMM_ADDR_STEP_DIST, 0, `JMM_RST_STEP_DIST, 0);
	access(0, `JMM_ADDR_STEP_PAUSE, 0, `JMM_RST_STEP_PAUSE, 0);
	access(0, 16'h0010, 0, 0, 1);
	access(1, `JMM_ADDR_JOG_CMD, 8, 0, 1);
	access(0, `JMM_ADDR_JOG_CMD, 0, 0, 0);
	access(1, `JMM_ADDR_SLOW_SPEED, 0, 0, 1);
	access(1, `JMM_ADDR_STEP_PAUSE, 32'h8000, 0, 1);
	$display("test registers done");
	enable_input = 1'b1;
	fault_clear_input = 1'b1;
	@(negedge clk_sys);
	check(fault_reset_pulse, 1);
	repeat (2) @(negedge clk_sys);
	check(fault_reset_pulse, 0);
	check(power_stage_en, 1);
	// Mode-specific control bits have no port here and stay zero
	access(1, `JMM_ADDR_MODE_SELECT, `JMM_MODE_JOG, 0, 0);
	check(jog_mode_active, 1);
	access(1, `JMM_ADDR_JOG_CMD, 1, 0, 0);
	repeat (3) @(negedge clk_sys);
	check({motion_run, motion_dir_neg}, 2'b10);
	check(speed_ref, `JMM_RST_SLOW_SPEED);
	access(1, `JMM_ADDR_JOG_CMD, 3, 0, 0);
	repeat (3) @(negedge clk_sys);
	check({motion_run, motion_dir_neg}, 2'b10);
	access(1, `JMM_ADDR_JOG_CMD, 5, 0, 0);
	repeat (2) @(negedge clk_sys);
	check(speed_ref, `JMM_RST_FAST_SPEED);
	access(1, `JMM_ADDR_JOG_CMD, 0, 0, 0);
	wait_state(3'h0);
	access(1, `JMM_ADDR_JOG_CMD, 3, 0, 0);
	repeat (4) @(negedge clk_sys);
	check(motion_run, 0);
	access(1, `JMM_ADDR_JOG_CMD, 6, 0, 0);
	repeat (3) @(negedge clk_sys);
	check({motion_run, motion_dir_neg}, 2'b11);
	halt_req = 1'b1;
	wait_state(3'h0);
	check(motion_run, 0);
	halt_req = 1'b0;
	repeat (2) @(negedge clk_sys);
	check({motion_run, motion_dir_neg}, 2'b11);
	access(1, `JMM_ADDR_JOG_CMD, 0, 0, 0);
	wait_state(3'h0);
	$display("test fieldbus done");
	access(1, `JMM_ADDR_STEP_DIST, 3, 0, 0);
	access(1, `JMM_ADDR_STEP_PAUSE, 2, 0, 0);
	cfg_di_jog = 1'b1;
	jog_method_step = 1'b1;
	positive_direction_input = 1'b1;
	wait_state(3'h2);
	check(motion_run, 0);
	n_wait = 0;
	while (jog_state === 3'h2 && n_wait < 1000) begin
		@(negedge clk_sys);
		n_wait = n_wait + 1;
	end
	check(n_wait, 2 * MS_TB);
	wait_state(3'h3);
	check({motion_run, motion_dir_neg}, 2'b10);
	positive_direction_input = 1'b0;
	wait_state(3'h0);
	negative_direction_input = 1'b1;
	repeat (2) @(negedge clk_sys);
	negative_direction_input = 1'b0;
	check({motion_run, motion_dir_neg}, 2'b11);
	repeat (40) @(negedge clk_sys);
	check(jog_state, 0);
	negative_direction_input = 1'b1;
	positive_direction_input = 1'b1;
	repeat (4) @(negedge clk_sys);
	check(motion_run, 0);
	negative_direction_input = 1'b0;
	jog_method_step = 1'b0;
	cfg_di_fast_slow = 1'b1;
	fast_slow_input = 1'b1;
	repeat (3) @(negedge clk_sys);
	check(speed_ref, `JMM_RST_FAST_SPEED);
	ramp_speed_limit = 16'h0064;
	repeat (3) @(negedge clk_sys);
	check(speed_ref, 16'h0064);
	check(motion_run, 1);
	positive_direction_input = 1'b0;
	wait_state(3'h0);
	$display("test inputs done");
	test_done;
end
endmodule
